// file: rtl/lps_pkg.sv
// package of constants, types and register map for the line protection switch
package lps_pkg;

    // request codes written by host software
    localparam logic [3:0] REQ_CLEAR = 4'h1;
    localparam logic [3:0] REQ_LOCKOUT = 4'h2;
    localparam logic [3:0] REQ_FORCE_WP = 4'h3;
    localparam logic [3:0] REQ_FORCE_PW = 4'h4;
    localparam logic [3:0] REQ_MAN_WP = 4'h5;
    localparam logic [3:0] REQ_MAN_PW = 4'h6;
    localparam logic [3:0] REQ_NONE = 4'h0;

    // request states, highest precedence first
    localparam logic [3:0] ST_LOCKOUT = 4'h1;
    localparam logic [3:0] ST_FORCED = 4'h2;
    localparam logic [3:0] ST_SIG_FAIL = 4'h3;
    localparam logic [3:0] ST_SIG_DEG = 4'h4;
    localparam logic [3:0] ST_MANUAL = 4'h5;
    localparam logic [3:0] ST_WTR = 4'h6;
    localparam logic [3:0] ST_REVERSE = 4'h8;
    localparam logic [3:0] ST_DNR = 4'h9;
    localparam logic [3:0] ST_NO_REQ = 4'ha;

    // wishbone register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_REQ = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;
    localparam logic [3:0] OFS_EVT = 4'hc;

    // ctrl field positions
    localparam int CTRL_REVERT = 0;
    localparam int CTRL_BIDIR = 1;
    localparam int CTRL_ONE_PLUS_ONE = 2;
    localparam int CTRL_SD_LSB = 8;

    // reset value and opposite-request limit
    localparam logic [31:0] CTRL_RST = 32'h0000_0004;
    localparam logic [1:0] MAX_OPPOSITE = 2'h2;

    // event log codes
    localparam logic [1:0] EVT_SF_OK = 2'h1;
    localparam logic [1:0] EVT_SF_FAIL = 2'h2;
    localparam logic [1:0] EVT_ERR_OPP = 2'h3;

    // per-line defect inputs
    typedef struct packed {
        logic loss_of_signal;
        logic loss_of_frame;
        logic line_ais;
        logic ber_above_1e3;
        logic [7:0] ber_exp;
    } lps_line_s;

    // whole state of the controller
    typedef struct packed {
        logic [31:0] dat;
        logic ack;
        logic revert;
        logic bidir;
        logic one_plus_one;
        logic [7:0] sd_thresh;
        logic [3:0] last_user;
        logic [3:0] req_state;
        logic on_prot;
        logic [1:0] opp_cnt;
        logic last_dir;
        logic blocked;
        logic pending;
        logic [1:0] evt_code;
        logic evt_src;
        logic evt_dst;
        logic [7:0] evt_cnt;
        logic rev_out;
    } lps_state_s;

endpackage : lps_pkg

// file: rtl/lps_ctrl.sv
// line protection switch controller with wishbone register access
// Functional notes
// - bidirectional switch makes far end reverse-request
// - clear in non-revertive gives do-not-revert state
// - clear in revertive gives no-request state
// - forced there and back blocks until clear
// - opposite requests at most twice in row
// - remember last request, switch when available
// - lockout selects working until clear or another request is accepted
// - forced switch ignores destination alarm
// - manual waits while destination alarmed, then switches
// - clear after forced resumes automatic switching
// - clear reinitialises, prefers healthier working line
// - protection signal fail overrides forced switch
// - reset starts clear, host resends request
// - revertive clear mode returns to working line
// - auto switch on fail only to healthy standby, on degrade to any non-degraded standby
// - signal-fail switch events off the working line logged with outcome
// - 1+1 mode bit only read back, switching ignores it
// - card switch only realigns to request
// - fixed precedence arbitrates request states
// - fail from defects, degrade from threshold
`timescale 1ns/1ps
`default_nettype none

module lps_ctrl (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire lps_pkg::lps_line_s i_work,
    input wire lps_pkg::lps_line_s i_prot,
    input wire logic i_far_reverse,
    input wire logic i_card_switch,
    output logic o_sel_prot,
    output logic o_reverse_req,
    output logic [3:0] o_req_state,
    output logic o_event
);

    lps_pkg::lps_state_s s_r;
    lps_pkg::lps_state_s s_nxt;

    // line condition decode
    logic w_sf, p_sf, w_sd, p_sd;
    logic wr_req, rd_req;
    logic [3:0] req_code;
    logic dst_bad;
    logic want_prot;
    logic bad_now;

    always_comb begin
        // fail on any hard defect, degrade on error-rate exponent threshold
        w_sf = i_work.loss_of_signal | i_work.loss_of_frame | i_work.line_ais
            | i_work.ber_above_1e3;
        p_sf = i_prot.loss_of_signal | i_prot.loss_of_frame | i_prot.line_ais
            | i_prot.ber_above_1e3;
        w_sd = (i_work.ber_exp != 8'h00) && (i_work.ber_exp <= s_r.sd_thresh);
        p_sd = (i_prot.ber_exp != 8'h00) && (i_prot.ber_exp <= s_r.sd_thresh);
    end

    always_comb begin
        // defaults hold state
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.evt_code = 2'h0;
        s_nxt.rev_out = 1'b0;
        // writes land on the edge that completes the cycle, when ack is seen
        wr_req = i_wb_cyc && i_wb_stb && i_wb_we && s_r.ack;
        rd_req = i_wb_cyc && i_wb_stb && !i_wb_we && !s_r.ack;
        req_code = REQ_NONE_f();
        dst_bad = 1'b0;
        want_prot = s_r.on_prot;
        bad_now = 1'b0;
        // classic single-cycle-latency slave
        if (i_wb_cyc && i_wb_stb && !s_r.ack) begin
            s_nxt.ack = 1'b1;
        end
        // read mux, unmapped reads zero
        if (rd_req) begin
            case (i_wb_adr)
                lps_pkg::OFS_CTRL: s_nxt.dat = {16'h0000, s_r.sd_thresh, 5'h00,
                    s_r.one_plus_one, s_r.bidir, s_r.revert};
                lps_pkg::OFS_REQ: s_nxt.dat = {28'h0000000, s_r.last_user};
                lps_pkg::OFS_STAT: s_nxt.dat = {16'h0000, s_r.last_user, s_r.req_state,
                    3'h0, s_r.blocked, s_r.pending, p_sf, w_sf, s_r.on_prot};
                lps_pkg::OFS_EVT: s_nxt.dat = {16'h0000, s_r.evt_cnt, 6'h00,
                    s_r.evt_src, s_r.evt_dst};
                default: s_nxt.dat = 32'h0000_0000;
            endcase
        end
        // control register write
        if (wr_req && i_wb_adr == lps_pkg::OFS_CTRL) begin
            if (i_wb_sel[0]) begin
                s_nxt.revert = i_wb_dat[lps_pkg::CTRL_REVERT];
                s_nxt.bidir = i_wb_dat[lps_pkg::CTRL_BIDIR];
                s_nxt.one_plus_one = i_wb_dat[lps_pkg::CTRL_ONE_PLUS_ONE];
            end
            if (i_wb_sel[1]) begin
                s_nxt.sd_thresh = i_wb_dat[lps_pkg::CTRL_SD_LSB +: 8];
            end
        end
        // request register write
        if (wr_req && i_wb_adr == lps_pkg::OFS_REQ && i_wb_sel[0]) begin
            req_code = i_wb_dat[3:0];
        end
        // external request handling
        case (req_code)
            lps_pkg::REQ_CLEAR: begin
                // reinitialise; revert choice picks state
                s_nxt.last_user = lps_pkg::REQ_CLEAR;
                s_nxt.opp_cnt = 2'h0;
                s_nxt.blocked = 1'b0;
                s_nxt.pending = 1'b0;
                s_nxt.req_state = s_r.revert ? lps_pkg::ST_NO_REQ
                    : lps_pkg::ST_DNR;
                // back to working only if working is healthier
                if (s_r.on_prot && (p_sf | p_sd) && !(w_sf | (w_sd & !p_sf))) begin
                    want_prot = 1'b0;
                end
            end
            lps_pkg::REQ_LOCKOUT, lps_pkg::REQ_FORCE_WP, lps_pkg::REQ_FORCE_PW,
            lps_pkg::REQ_MAN_WP, lps_pkg::REQ_MAN_PW: begin
                if (s_r.blocked || (s_r.opp_cnt == lps_pkg::MAX_OPPOSITE)) begin
                    // third opposite request is refused and logged
                    s_nxt.blocked = 1'b1;
                    s_nxt.evt_code = lps_pkg::EVT_ERR_OPP;
                end else begin
                    s_nxt.last_user = req_code;
                    s_nxt.pending = 1'b1;
                    s_nxt.opp_cnt = s_r.opp_cnt + 2'h1;
                    s_nxt.last_dir = (req_code == lps_pkg::REQ_FORCE_WP)
                        || (req_code == lps_pkg::REQ_MAN_WP);
                end
            end
            default: begin
                // no request this cycle
            end
        endcase
        // card swap realigns only to remembered request
        if (i_card_switch && s_r.last_user != lps_pkg::REQ_CLEAR) begin
            s_nxt.pending = 1'b1;
        end
        // arbitration over the remembered request, by precedence
        if (p_sf && s_r.on_prot && s_r.last_user != lps_pkg::REQ_LOCKOUT) begin
            // protection failure beats forced, even onto failed working
            want_prot = 1'b0;
            s_nxt.req_state = lps_pkg::ST_SIG_FAIL;
        end else if (req_code == lps_pkg::REQ_CLEAR) begin
            // clear taken this cycle owns the state; the old request must not
            // overwrite it, arbitration resumes on the next cycle
            s_nxt.pending = 1'b0;
        end else if (s_r.last_user == lps_pkg::REQ_LOCKOUT) begin
            want_prot = 1'b0;
            s_nxt.req_state = lps_pkg::ST_LOCKOUT;
            s_nxt.pending = 1'b0;
        end else if (s_r.last_user == lps_pkg::REQ_FORCE_WP
                || s_r.last_user == lps_pkg::REQ_FORCE_PW) begin
            if (s_r.pending) begin
                want_prot = s_r.last_user == lps_pkg::REQ_FORCE_WP;
                s_nxt.pending = 1'b0;
            end
            s_nxt.req_state = lps_pkg::ST_FORCED;
        end else if (s_r.on_prot ? p_sf : w_sf) begin
            // active line failed: move only to healthy standby
            bad_now = 1'b1;
            s_nxt.req_state = lps_pkg::ST_SIG_FAIL;
            if (!(s_r.on_prot ? w_sf : p_sf)) begin
                want_prot = !s_r.on_prot;
                s_nxt.evt_code = lps_pkg::EVT_SF_OK;
            end else begin
                s_nxt.evt_code = lps_pkg::EVT_SF_FAIL;
            end
            s_nxt.evt_src = s_r.on_prot;
            s_nxt.evt_dst = !s_r.on_prot;
        end else if (s_r.on_prot ? (p_sd & !w_sd) : (w_sd & !p_sd)) begin
            want_prot = !s_r.on_prot;
            s_nxt.req_state = lps_pkg::ST_SIG_DEG;
        end else if (s_r.last_user == lps_pkg::REQ_MAN_WP
                || s_r.last_user == lps_pkg::REQ_MAN_PW) begin
            s_nxt.req_state = lps_pkg::ST_MANUAL;
            // wait while destination alarmed, then switch
            dst_bad = (s_r.last_user == lps_pkg::REQ_MAN_WP) ? (p_sf | p_sd)
                : (w_sf | w_sd);
            if (s_r.pending && !dst_bad) begin
                want_prot = s_r.last_user == lps_pkg::REQ_MAN_WP;
                s_nxt.pending = 1'b0;
            end
        end else if (i_far_reverse && s_r.bidir) begin
            s_nxt.req_state = lps_pkg::ST_REVERSE;
        end else if (s_r.last_user == lps_pkg::REQ_CLEAR && s_r.revert
                && s_r.on_prot && !w_sf && !w_sd) begin
            // revertive clear mode settles on working
            want_prot = 1'b0;
            s_nxt.req_state = lps_pkg::ST_NO_REQ;
        end
        s_nxt.on_prot = want_prot;
        // tell far end we switched in bidirectional mode
        if (want_prot != s_r.on_prot && s_r.bidir) begin
            s_nxt.rev_out = 1'b1;
        end
        if (s_nxt.evt_code != 2'h0) begin
            s_nxt.evt_cnt = s_r.evt_cnt + 8'h01;
        end
        if (bad_now && s_nxt.evt_code == 2'h0) begin
            s_nxt.evt_code = lps_pkg::EVT_SF_FAIL;
        end
    end

    // constant helper keeps request default in one place
    function automatic logic [3:0] REQ_NONE_f();
        return lps_pkg::REQ_NONE;
    endfunction : REQ_NONE_f

    // state register; reset starts in clear automatic mode on working
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r <= '0;
            s_r.revert <= lps_pkg::CTRL_RST[lps_pkg::CTRL_REVERT];
            s_r.one_plus_one <= lps_pkg::CTRL_RST[lps_pkg::CTRL_ONE_PLUS_ONE];
            s_r.last_user <= lps_pkg::REQ_CLEAR;
            s_r.req_state <= lps_pkg::ST_NO_REQ;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state flops
    assign o_wb_dat = s_r.dat;
    assign o_wb_ack = s_r.ack;
    assign o_sel_prot = s_r.on_prot;
    assign o_reverse_req = s_r.rev_out;
    assign o_req_state = s_r.req_state;
    assign o_event = s_r.evt_code != 2'h0;

endmodule : lps_ctrl

`default_nettype wire

// file: sim/lps_far_end.sv
// far-end protection controller model across the line pair
`timescale 1ns/1ps
`default_nettype none

module lps_far_end (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_rev_req,
    input wire logic i_switch,
    output logic o_far_reverse,
    output logic [3:0] o_state
);
    // far end notes why it follows our switch
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_state <= lps_pkg::ST_NO_REQ;
        end else if (i_rev_req) begin
            o_state <= lps_pkg::ST_REVERSE;
        end
    end

    // own switch only when the bench asks, so no echo loop forms
    assign o_far_reverse = i_switch;
endmodule : lps_far_end
`default_nettype wire

// file: sim/lps_ctrl_chk.sv
// port checker for the line protection switch controller
`timescale 1ns/1ps
`default_nettype none

module lps_ctrl_chk (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic o_wb_ack,
    input wire lps_pkg::lps_line_s i_work,
    input wire lps_pkg::lps_line_s i_prot,
    input wire logic o_sel_prot,
    input wire logic o_reverse_req,
    input wire logic [3:0] o_req_state,
    input wire logic o_event
);
    logic bidir_r; // mirror of the bidirectional bit
    logic sf_w; // working line signal fail
    logic sf_p; // protection line signal fail
    assign sf_w = i_work.loss_of_signal | i_work.loss_of_frame | i_work.line_ais
        | i_work.ber_above_1e3;
    assign sf_p = i_prot.loss_of_signal | i_prot.loss_of_frame | i_prot.line_ais
        | i_prot.ber_above_1e3;
    // track ctrl writes; they land on the ack edge, as in the design
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bidir_r <= 1'b0;
        end else if (o_wb_ack && i_wb_we && i_wb_adr == lps_pkg::OFS_CTRL && i_wb_sel[0]) begin
            bidir_r <= i_wb_dat[lps_pkg::CTRL_BIDIR];
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // working line fails while idle in automatic mode
    sequence auto_sw_s;
        $rose(sf_w) && !sf_p && !o_sel_prot
            && (o_req_state == lps_pkg::ST_NO_REQ || o_req_state == lps_pkg::ST_DNR);
    endsequence
    ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held past one cycle");
    ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    rev_bidir_a: assert property (o_reverse_req |-> bidir_r)
        else $error("reverse indication outside bidirectional mode");
    rev_switch_a: assert property (bidir_r && $changed(o_sel_prot) |-> ##[0:1] o_reverse_req)
        else $error("bidirectional switch without reverse indication");
    lock_work_a: assert property (
        o_req_state == lps_pkg::ST_LOCKOUT && $past(o_req_state) == lps_pkg::ST_LOCKOUT
            |-> !o_sel_prot) else $error("lockout left protection active");
    pfail_work_a: assert property (sf_p [*3] |-> !o_sel_prot)
        else $error("protection active while it fails");
    auto_sw_a: assert property (auto_sw_s |-> ##[1:3] o_sel_prot)
        else $error("no automatic switch to healthy standby");
    sf_event_a: assert property (auto_sw_s |-> ##[1:3] o_event)
        else $error("signal fail switch not logged");
    rst_state_a: assert property (disable iff (1'b0) $past(i_rst)
        |-> o_req_state == lps_pkg::ST_NO_REQ && !o_sel_prot) else $error("bad reset state");
    cover property (o_reverse_req);
    cover property (o_event);
    cover property (o_req_state == lps_pkg::ST_LOCKOUT);
endmodule : lps_ctrl_chk

bind lps_ctrl lps_ctrl_chk chk (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .i_work(i_work), .i_prot(i_prot),
    .o_sel_prot(o_sel_prot), .o_reverse_req(o_reverse_req), .o_req_state(o_req_state),
    .o_event(o_event));
`default_nettype wire

// file: sim/lps_ctrl_tb.sv
// self-checking bench for the line protection switch controller
`timescale 1ns/1ps
`default_nettype none

module lps_ctrl_tb;
    logic clock, rst, cyc, stb, we, card_sw, far_sw, far_rev, sel_prot, rev_req, evt, ack;
    logic [3:0] adr, st, far_st;
    logic [31:0] wdat, rdat, q;
    lps_pkg::lps_line_s work, prot; // line defect stimulus
    int error_cnt, n_tests;

    lps_ctrl uut (.i_clock(clock), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_work(work), .i_prot(prot), .i_far_reverse(far_rev), .i_card_switch(card_sw),
        .o_sel_prot(sel_prot), .o_reverse_req(rev_req), .o_req_state(st), .o_event(evt));
    lps_far_end far (.i_clock(clock), .i_rst(rst), .i_rev_req(rev_req), .i_switch(far_sw),
        .o_far_reverse(far_rev), .o_state(far_st));

    // 10 MHz clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // one classic cycle; ack and read data are taken at the rising edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            cmp("wb ack", 32'h1, 32'h0);
            print_verdict();
        end
        // idle cycle so the next request never meets a standing ack
        @(posedge clock);
    endtask : wb

    task automatic req(input logic [3:0] c);
        wb(1'b1, lps_pkg::OFS_REQ, {28'h0, c});
    endtask : req

    // settle, then compare active line and state; 4'hf skips a field
    task automatic look(input logic [3:0] s, input logic [3:0] e);
        repeat (3) @(posedge clock);
        @(negedge clock);
        if (s !== 4'hf) cmp("sel_prot", {31'h0, s[0]}, {31'h0, sel_prot});
        if (e !== 4'hf) cmp("req_state", {28'h0, e}, {28'h0, st});
        @(posedge clock);
    endtask : look

    initial begin
        rst = 1'b1;
        {cyc, stb, we, card_sw, far_sw} = 5'h00;
        adr = 4'h0;
        wdat = 32'h0;
        work = '0;
        prot = '0;
        error_cnt = 0;
        n_tests = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        look(4'h0, lps_pkg::ST_NO_REQ);
        wb(1'b0, lps_pkg::OFS_CTRL, 32'h0);
        cmp("ctrl reset", lps_pkg::CTRL_RST, q);
        wb(1'b1, lps_pkg::OFS_CTRL, 32'h0000_0606); // bidir, non-revertive, degrade at 6
        prot.ber_exp <= 8'h05; // protection degraded
        req(lps_pkg::REQ_FORCE_WP);
        look(4'h1, lps_pkg::ST_FORCED);
        cmp("far state", {28'h0, lps_pkg::ST_REVERSE}, {28'h0, far_st});
        prot.ber_exp <= 8'h00;
        req(lps_pkg::REQ_CLEAR);
        look(4'h1, lps_pkg::ST_DNR);
        req(lps_pkg::REQ_FORCE_PW);
        look(4'h0, lps_pkg::ST_FORCED);
        req(lps_pkg::REQ_FORCE_WP);
        look(4'h1, lps_pkg::ST_FORCED);
        req(lps_pkg::REQ_FORCE_PW); // third in a row must be refused
        look(4'h1, lps_pkg::ST_FORCED);
        prot.loss_of_signal <= 1'b1;
        look(4'h0, 4'hf);
        req(lps_pkg::REQ_CLEAR);
        look(4'h0, 4'hf);
        prot.loss_of_signal <= 1'b0;
        look(4'h0, 4'hf);
        work.loss_of_signal <= 1'b1;
        look(4'h1, 4'hf);
        work.loss_of_signal <= 1'b0;
        far_sw <= 1'b1; // far end switches on its own
        look(4'h1, lps_pkg::ST_REVERSE);
        far_sw <= 1'b0;
        wb(1'b1, lps_pkg::OFS_CTRL, 32'h0000_0607); // now revertive
        req(lps_pkg::REQ_LOCKOUT);
        look(4'h0, lps_pkg::ST_LOCKOUT);
        work.loss_of_signal <= 1'b1;
        look(4'h0, lps_pkg::ST_LOCKOUT);
        work.loss_of_signal <= 1'b0;
        req(lps_pkg::REQ_CLEAR);
        look(4'h0, lps_pkg::ST_NO_REQ);
        prot.ber_exp <= 8'h05;
        req(lps_pkg::REQ_MAN_WP);
        look(4'h0, 4'hf);
        prot.ber_exp <= 8'h00;
        look(4'h1, lps_pkg::ST_MANUAL);
        card_sw <= 1'b1;
        @(posedge clock);
        card_sw <= 1'b0;
        look(4'h1, lps_pkg::ST_MANUAL);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        look(4'h0, lps_pkg::ST_NO_REQ);
        req(lps_pkg::REQ_MAN_WP); // host resends its last request
        look(4'h1, lps_pkg::ST_MANUAL);
        print_verdict();
    end
endmodule : lps_ctrl_tb
`default_nettype wire
